// ---- pkg/ata_pkg.sv ----
// Shared constants for the power-query / stream-configuration command handler.
// Assumes one 10 MHz clock shared by both ends of the taskfile link.
package ata_pkg;
    // Command opcodes
    localparam logic [7:0] OP_POWER_QUERY     = 8'hE5;
    localparam logic [7:0] OP_POWER_QUERY_ALT = 8'h98;
    localparam logic [7:0] OP_STREAM_CFG      = 8'h51;
    // Power condition codes returned in sector count
    localparam logic [7:0] PWR_IDLE_LEGACY    = 8'hFF;
    localparam logic [7:0] PWR_IDLE_STD       = 8'h80;
    localparam logic [7:0] PWR_STANDBY_LEGACY = 8'h00;
    localparam logic [7:0] PWR_IDLE_A         = 8'h81;
    localparam logic [7:0] PWR_IDLE_B         = 8'h82;
    localparam logic [7:0] PWR_IDLE_C         = 8'h83;
    localparam logic [7:0] PWR_STANDBY_Y      = 8'h01;
    localparam logic [7:0] PWR_STANDBY_Z      = 8'h00;
    typedef enum logic [2:0] {
        PC_IDLE_A    = 3'h0,
        PC_IDLE_B    = 3'h1,
        PC_IDLE_C    = 3'h2,
        PC_STANDBY_Y = 3'h3,
        PC_STANDBY_Z = 3'h4
    } power_cond_e;
    typedef enum logic [1:0] {CK_POWER, CK_STREAM, CK_UNKNOWN} cmd_kind_e;
    // Feature byte and device/head fields
    localparam int FEAT_ADD_BIT   = 7;
    localparam int FEAT_WRITE_BIT = 6;
    localparam int FEAT_ID_LSB    = 0;
    localparam int ID_W           = 3;
    localparam int DH_RETRY_BIT   = 7;
    localparam int DH_LBA_BIT     = 6;
    localparam int DH_DEV_BIT     = 4;
    // Status and error bits
    localparam int ST_BSY  = 7;
    localparam int ST_RDY  = 6;
    localparam int ST_DSC  = 4;
    localparam int ST_ERR  = 0;
    localparam int ERR_ABT = 2;
    localparam logic [7:0] STATUS_RESET = 8'h50;
    localparam logic [7:0] ERROR_RESET  = 8'h00;
    // Timing
    localparam int CLK_HZ        = 10_000_000;
    localparam int HZ_PER_MHZ    = 1_000_000;
    localparam int CYCLES_PER_US = CLK_HZ / HZ_PER_MHZ;
    localparam int LIMIT_W           = 40;
    localparam int DFLT_MIN_LIMIT_US = 1000;
    // Host command port map and fields
    localparam logic [7:0] HREG_CMD    = 8'h00;
    localparam logic [7:0] HREG_ALLOC  = 8'h04;
    localparam logic [7:0] HREG_FACTOR = 8'h08;
    localparam logic [7:0] HREG_RESULT = 8'h0C;
    localparam int CMD_STREAM_BIT = 0;
    localparam int CMD_ADD_BIT    = 1;
    localparam int CMD_WRITE_BIT  = 2;
    localparam int CMD_ID_LSB     = 3;
    localparam int CMD_LBA_BIT    = 6;
    localparam int CMD_ALT_BIT    = 7;
    localparam int RES_BUSY_BIT   = 24;
    localparam int RES_DONE_BIT   = 25;
endpackage

// ---- pkg/ata_cmd_if.sv ----
// Taskfile link between the host-adapter end and the device end.
// Assumes both ends run on the same clock; the bench joins them.
`timescale 1ns/1ns
interface ata_cmd_if;
    // Host to device taskfile
    logic [7:0] feat_cur;
    logic [7:0] feat_prev;
    logic [7:0] count_cur;
    logic [7:0] count_prev;
    logic [7:0] dev_head;
    logic [7:0] command;
    logic       cmd_wr;
    // Device to host results
    logic [7:0] status;
    logic [7:0] error;
    logic [7:0] count_ret;
    logic       intrq;

    modport host_end (
        output feat_cur, feat_prev, count_cur, count_prev, dev_head, command, cmd_wr,
        input  status, error, count_ret, intrq
    );
    modport dev_end (
        input  feat_cur, feat_prev, count_cur, count_prev, dev_head, command, cmd_wr,
        output status, error, count_ret, intrq
    );
endinterface // ata_cmd_if

// ---- core/ata_completion_time_limit_timer.sv ----
// Completion-time-limit watchdog in whole microseconds.
// Assumes start and stop are one-cycle pulses and the limit holds while running.
`timescale 1ns/1ns
module ata_limit_timer
    import ata_pkg::*;
#(
    parameter int CYC_PER_US = CYCLES_PER_US,
    parameter int W          = LIMIT_W
) (
    // Clock and reset
    input  wire logic         sys_clk_in,
    input  wire logic         rst_b_in,
    // Control
    input  wire logic         start_in,
    input  wire logic         stop_in,
    input  wire logic [W-1:0] limit_in,
    // Result
    output logic              overrun_out
);
    logic [15:0]  div_reg;
    logic         run_reg;
    logic [W-1:0] us_reg;
    logic         tick;

    // One-microsecond enable from the clock divider
    assign tick = run_reg && (div_reg == 16'(CYC_PER_US - 1));

    // Divider restarts with each start so the first microsecond is whole
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            div_reg <= '0;
        end else if (start_in || tick || !run_reg) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 16'h0001;
        end
    end

    // Run flag and elapsed microseconds
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            run_reg <= 1'b0;
            us_reg  <= '0;
        end else if (start_in) begin
            run_reg <= 1'b1;
            us_reg  <= '0;
        end else begin
            if (stop_in) begin
                run_reg <= 1'b0;
            end
            if (tick) begin
                us_reg <= us_reg + W'(1);
            end
        end
    end

    // Sticky overrun until the next start
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            overrun_out <= 1'b0;
        end else if (start_in) begin
            overrun_out <= 1'b0;
        end else if (tick && !stop_in && us_reg >= limit_in) begin
            overrun_out <= 1'b1;
        end
    end
endmodule // ata_limit_timer

// ---- core/ata_dev_end.sv ----
// Device end: decodes power-query and stream-configuration commands.
// Assumes the host waits for the interrupt before writing the next command.
// What this block does
// - Power query decoded from E5h or 98h
// - Legacy power mode idle returns FFh
// - Legacy power mode standby returns zero
// - Extended mode returns idle/standby condition codes
// - Opcode 51h is stream configuration
// - Add replaces valid stream; abort keeps old
// - Abort when streaming is unsupported
// - Abort removal of never-configured stream
// - Feature bit 7: add or remove
// - Feature bit 6: read or write stream
// - Feature bits 2..0 hold stream identifier
// - Default limit is previous feature times unit
// - Zero limit uses stored per-stream default
// - Limit timed from stream start pulse to stream done pulse
// - Limit below minimum is raised to minimum
// - Allocation unit: low byte current, high previous
// - Device/head bit 6 selects CHS or LBA
// - Retry bit value changes nothing
// - Device/head bit 4 is ignored
// - Final status and error set on the same edge as the interrupt
`timescale 1ns/1ns
module ata_dev_end
    import ata_pkg::*;
#(
    parameter int NUM_STREAMS = 8,
    parameter int MIN_LIMIT_US = DFLT_MIN_LIMIT_US
) (
    // Clock and reset
    input  wire logic               sys_clk_in,
    input  wire logic               rst_b_in,
    // Taskfile link
    ata_cmd_if.dev_end              tf,
    // Drive condition
    input  wire logic               epc_enabled_in,
    input  wire logic [2:0]         power_cond_in,
    input  wire logic               stream_supported_in,
    input  wire logic [31:0]        ident_limit_unit_in,
    // Streaming command activity
    input  wire logic               strm_start_in,
    input  wire logic [ID_W-1:0]    strm_id_in,
    input  wire logic [LIMIT_W-1:0] strm_limit_in,
    input  wire logic               strm_done_in,
    // Results
    output logic                    lba_mode_out,
    output logic [NUM_STREAMS-1:0]  strm_valid_out,
    output logic [NUM_STREAMS-1:0]  strm_is_write_out,
    output logic [LIMIT_W-1:0]      strm_limit_out,
    output logic                    strm_overrun_out
);
    typedef enum logic {S_IDLE = 1'b0, S_EXEC = 1'b1} dev_state_e;

    dev_state_e         state_reg;
    logic [7:0]         op_reg;
    logic [7:0]         feat_cur_reg;
    logic [7:0]         feat_prev_reg;
    logic [7:0]         cnt_cur_reg;
    logic [7:0]         cnt_prev_reg;
    logic [7:0]         status_reg;
    logic [7:0]         error_reg;
    logic [7:0]         count_ret_reg;
    logic               intrq_reg;
    logic [LIMIT_W-1:0] dflt_reg  [NUM_STREAMS];
    logic [15:0]        alloc_reg [NUM_STREAMS];
    logic [ID_W-1:0]    cfg_id;
    logic               cfg_add;
    cmd_kind_e          kind;
    logic               abort;
    logic [7:0]         pwr_code;
    logic [LIMIT_W-1:0] req_lim;
    logic [LIMIT_W-1:0] eff_lim;

    // Opcode classification
    function automatic cmd_kind_e decode_cmd(input logic [7:0] op);
        if (op == OP_POWER_QUERY || op == OP_POWER_QUERY_ALT) begin
            decode_cmd = CK_POWER;
        end else if (op == OP_STREAM_CFG) begin
            decode_cmd = CK_STREAM;
        end else begin
            decode_cmd = CK_UNKNOWN;
        end
    endfunction

    assign kind    = decode_cmd(op_reg);
    assign cfg_id  = feat_cur_reg[FEAT_ID_LSB +: ID_W];
    assign cfg_add = feat_cur_reg[FEAT_ADD_BIT];

    // Abort conditions; unknown opcodes are refused the same way
    always_comb begin
        abort = 1'b0;
        if (kind == CK_UNKNOWN) begin
            abort = 1'b1;
        end else if (kind == CK_STREAM) begin
            abort = !stream_supported_in
                  || (!cfg_add && !strm_valid_out[cfg_id]);
        end
    end

    // Power condition code
    always_comb begin
        pwr_code = PWR_IDLE_A;
        if (epc_enabled_in) begin
            case (power_cond_in)
                PC_IDLE_A:    pwr_code = PWR_IDLE_A;
                PC_IDLE_B:    pwr_code = PWR_IDLE_B;
                PC_IDLE_C:    pwr_code = PWR_IDLE_C;
                PC_STANDBY_Y: pwr_code = PWR_STANDBY_Y;
                PC_STANDBY_Z: pwr_code = PWR_STANDBY_Z;
                default:      pwr_code = PWR_STANDBY_Z;
            endcase
        end else if (power_cond_in == PC_STANDBY_Y || power_cond_in == PC_STANDBY_Z) begin
            pwr_code = PWR_STANDBY_LEGACY;
        end else begin
            pwr_code = PWR_IDLE_LEGACY; // Not PWR_IDLE_STD
        end
    end

    // Command sequencer; new writes are ignored while busy
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg <= S_IDLE;
        end else begin
            case (state_reg)
                S_IDLE:  state_reg <= tf.cmd_wr ? S_EXEC : S_IDLE;
                S_EXEC:  state_reg <= S_IDLE;
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // Taskfile capture on command write; device/head bits 7, 5, 4 unused
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            op_reg        <= '0;
            feat_cur_reg  <= '0;
            feat_prev_reg <= '0;
            cnt_cur_reg   <= '0;
            cnt_prev_reg  <= '0;
            lba_mode_out  <= 1'b0;
        end else if (state_reg == S_IDLE && tf.cmd_wr) begin
            op_reg        <= tf.command;
            feat_cur_reg  <= tf.feat_cur;
            feat_prev_reg <= tf.feat_prev;
            cnt_cur_reg   <= tf.count_cur;
            cnt_prev_reg  <= tf.count_prev;
            lba_mode_out  <= tf.dev_head[DH_LBA_BIT];
        end
    end

    // Results land on the same edge as the interrupt pulse
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            status_reg    <= STATUS_RESET;
            error_reg     <= ERROR_RESET;
            count_ret_reg <= '0;
            intrq_reg     <= 1'b0;
        end else begin
            intrq_reg <= 1'b0;
            if (state_reg == S_IDLE && tf.cmd_wr) begin
                status_reg[ST_BSY] <= 1'b1;
            end else if (state_reg == S_EXEC) begin
                intrq_reg  <= 1'b1;
                status_reg <= STATUS_RESET;
                error_reg  <= ERROR_RESET;
                if (abort) begin
                    status_reg[ST_ERR] <= 1'b1;
                    error_reg[ERR_ABT] <= 1'b1;
                end else if (kind == CK_POWER) begin
                    count_ret_reg <= pwr_code;
                end
            end
        end
    end

    // Stream table; an aborted command leaves every entry untouched
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            strm_valid_out    <= '0;
            strm_is_write_out <= '0;
            for (int i = 0; i < NUM_STREAMS; i++) begin
                dflt_reg[i]  <= '0;
                alloc_reg[i] <= '0;
            end
        end else if (state_reg == S_EXEC && kind == CK_STREAM && !abort) begin
            if (cfg_add) begin
                strm_valid_out[cfg_id]    <= 1'b1;
                strm_is_write_out[cfg_id] <= feat_cur_reg[FEAT_WRITE_BIT];
                dflt_reg[cfg_id]  <= LIMIT_W'(feat_prev_reg)
                                     * LIMIT_W'(ident_limit_unit_in);
                alloc_reg[cfg_id] <= {cnt_prev_reg, cnt_cur_reg};
            end else begin
                strm_valid_out[cfg_id] <= 1'b0;
            end
        end
    end

    // Effective limit for a streaming command
    always_comb begin
        req_lim = (strm_limit_in == '0) ? dflt_reg[strm_id_in] : strm_limit_in;
        eff_lim = (req_lim < LIMIT_W'(MIN_LIMIT_US)) ? LIMIT_W'(MIN_LIMIT_US)
                                                     : req_lim;
    end

    // Latched limit for the command in flight
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            strm_limit_out <= '0;
        end else if (strm_start_in) begin
            strm_limit_out <= eff_lim;
        end
    end

    // Watchdog from strm_start_in pulse to strm_done_in pulse
    ata_limit_timer #(
        .CYC_PER_US (CYCLES_PER_US),
        .W          (LIMIT_W)
    ) u_timer (
        .sys_clk_in  (sys_clk_in),
        .rst_b_in    (rst_b_in),
        .start_in    (strm_start_in),
        .stop_in     (strm_done_in),
        .limit_in    (strm_limit_out),
        .overrun_out (strm_overrun_out)
    );

    // Link outputs straight from flops
    assign tf.status    = status_reg;
    assign tf.error     = error_reg;
    assign tf.count_ret = count_ret_reg;
    assign tf.intrq     = intrq_reg;
endmodule // ata_dev_end

// ---- core/ata_host_end.sv ----
// Host-adapter end: software orders a command, this end writes the taskfile.
// Assumes a plain register port; read data appear the cycle after the strobe.
`timescale 1ns/1ns
module ata_host_end
    import ata_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rst_b_in,
    // Register port
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic [31:0]      rdata_out,
    // Taskfile link
    ata_cmd_if.host_end      tf
);
    logic       busy_reg;
    logic       done_reg;
    logic [15:0] alloc_reg;
    logic [7:0] factor_reg;
    logic [7:0] res_status_reg;
    logic [7:0] res_error_reg;
    logic [7:0] res_count_reg;
    logic [7:0] feat_cur_reg;
    logic [7:0] feat_prev_reg;
    logic [7:0] cnt_cur_reg;
    logic [7:0] cnt_prev_reg;
    logic [7:0] dev_head_reg;
    logic [7:0] command_reg;
    logic       cmd_wr_reg;
    logic       go;

    // A command order is taken only while idle
    assign go = wr_in && addr_in == HREG_CMD && !busy_reg;

    // Parameter registers
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            alloc_reg  <= '0;
            factor_reg <= '0;
        end else if (wr_in && addr_in == HREG_ALLOC) begin
            alloc_reg <= wdata_in[15:0];
        end else if (wr_in && addr_in == HREG_FACTOR) begin
            factor_reg <= wdata_in[7:0];
        end
    end

    // Taskfile build and command write pulse
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            feat_cur_reg  <= '0;
            feat_prev_reg <= '0;
            cnt_cur_reg   <= '0;
            cnt_prev_reg  <= '0;
            dev_head_reg  <= '0;
            command_reg   <= '0;
            cmd_wr_reg    <= 1'b0;
        end else begin
            cmd_wr_reg <= go;
            if (go) begin
                feat_cur_reg  <= '0;
                feat_prev_reg <= '0;
                cnt_cur_reg   <= '0;
                cnt_prev_reg  <= '0;
                dev_head_reg  <= '0; // Retry and device bits written as zero
                dev_head_reg[DH_LBA_BIT] <= wdata_in[CMD_LBA_BIT];
                if (wdata_in[CMD_STREAM_BIT]) begin
                    command_reg <= OP_STREAM_CFG;
                    feat_cur_reg[FEAT_ADD_BIT]   <= wdata_in[CMD_ADD_BIT];
                    feat_cur_reg[FEAT_WRITE_BIT] <= wdata_in[CMD_WRITE_BIT];
                    feat_cur_reg[FEAT_ID_LSB +: ID_W] <= wdata_in[CMD_ID_LSB +: ID_W];
                    feat_prev_reg <= factor_reg;
                    cnt_cur_reg   <= alloc_reg[7:0];
                    cnt_prev_reg  <= alloc_reg[15:8];
                end else begin
                    command_reg <= wdata_in[CMD_ALT_BIT] ? OP_POWER_QUERY_ALT
                                                        : OP_POWER_QUERY;
                end
            end
        end
    end

    // Busy until interrupt; done is sticky and a new result beats its clear
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            busy_reg       <= 1'b0;
            done_reg       <= 1'b0;
            res_status_reg <= STATUS_RESET;
            res_error_reg  <= ERROR_RESET;
            res_count_reg  <= '0;
        end else begin
            if (go) begin
                busy_reg <= 1'b1;
            end else if (busy_reg && tf.intrq) begin
                busy_reg <= 1'b0;
            end
            if (busy_reg && tf.intrq) begin
                done_reg       <= 1'b1;
                res_status_reg <= tf.status;
                res_error_reg  <= tf.error;
                res_count_reg  <= tf.count_ret;
            end else if (rd_in && addr_in == HREG_RESULT) begin
                done_reg <= 1'b0;
            end
        end
    end

    // Read port; unmapped addresses read zero
    always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_out <= '0;
        end else begin
            rdata_out <= '0;
            if (rd_in) begin
                case (addr_in)
                    HREG_ALLOC:  rdata_out[15:0] <= alloc_reg;
                    HREG_FACTOR: rdata_out[7:0]  <= factor_reg;
                    HREG_RESULT: rdata_out <= {6'h00, done_reg, busy_reg, res_status_reg,
                                               res_error_reg, res_count_reg};
                    default:     rdata_out <= '0;
                endcase
            end
        end
    end

    // Link outputs straight from flops
    assign tf.feat_cur   = feat_cur_reg;
    assign tf.feat_prev  = feat_prev_reg;
    assign tf.count_cur  = cnt_cur_reg;
    assign tf.count_prev = cnt_prev_reg;
    assign tf.dev_head   = dev_head_reg;
    assign tf.command    = command_reg;
    assign tf.cmd_wr     = cmd_wr_reg;
endmodule // ata_host_end

// ---- test/ata_link_chk.sv ----
// Assertions on the taskfile link between the two ends.
// Assumes the bench instantiates it beside the interface.
`timescale 1ns/1ns
module ata_link_chk
    import ata_pkg::*;
(
    // Clock and reset
    input wire logic       sys_clk_in,
    input wire logic       rst_b_in,
    // Link signals
    input wire logic [7:0] command,
    input wire logic       cmd_wr,
    input wire logic [7:0] status,
    input wire logic [7:0] error,
    input wire logic [7:0] count_ret,
    input wire logic       intrq
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    // Opcode class, held on the link until the next write
    wire pq  = command == OP_POWER_QUERY || command == OP_POWER_QUERY_ALT;
    wire cfg = command == OP_STREAM_CFG;
    AST_INTR_LAT: assert property (cmd_wr |-> ##2 intrq)
        else $error("late interrupt");
    AST_BSY_WIN: assert property (cmd_wr |=> status[ST_BSY] ##1 !status[ST_BSY])
        else $error("bad busy window");
    AST_BSY_CAUSE: assert property ($rose(status[ST_BSY]) |-> $past(cmd_wr))
        else $error("busy without write");
    AST_DONE_RDY: assert property (intrq |-> status[ST_RDY] ##1 !intrq)
        else $error("bad completion");
    AST_ABT_PAIR: assert property (intrq |-> error[ERR_ABT] == status[ST_ERR])
        else $error("abort and error bits differ");
    AST_PQ_OK: assert property (intrq && pq |-> !status[ST_ERR])
        else $error("power query aborted");
    AST_PQ_CODE: assert property (intrq && pq |->
        count_ret inside {8'hFF, 8'h00, 8'h81, 8'h82, 8'h83, 8'h01})
        else $error("bad power code");
    AST_CFG_CNT: assert property (intrq && cfg |-> $stable(count_ret))
        else $error("count changed by stream config");
    AST_ABT_CODE: assert property (intrq && status[ST_ERR] |->
        status == 8'h51 && error == 8'h04)
        else $error("abort result not as coded");
    // Main scenarios reached
    cover property (intrq && pq);
    cover property (intrq && cfg && !status[ST_ERR]);
    cover property (intrq && status[ST_ERR]);
endmodule // ata_link_chk

// ---- test/ata_power_stream_cmd_handler_tb.sv ----
// Bench joining host and device ends over the taskfile link.
// Assumes software reaches the host end through its register port.
`timescale 1ns/1ns
module ata_power_stream_cmd_handler_tb;
    import ata_pkg::*;
    localparam int MIN_US = 4;
    // One table case: order, drive condition, expected result
    typedef struct packed {
        logic [7:0]  cmd;
        logic        epc;
        logic [2:0]  pc;
        logic        sup;
        logic [23:0] res;
    } row_s;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [31:0] r;
    logic        epc = 1'b0;
    logic        sup = 1'b1;
    logic [2:0]  pc = 3'h0;
    logic [31:0] ident = 32'h2;
    logic        s_go = 1'b0;
    logic        s_end = 1'b0;
    logic [2:0]  s_id = 3'h2;
    logic [39:0] s_lim = 40'h0;
    logic        lba;
    logic        ovr;
    logic [7:0]  vld;
    logic [7:0]  wrs;
    logic [39:0] lim;
    logic [47:0] snap = 48'h0;
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          n_wr = 0;
    int          w0;
    row_s        rows [12];

    ata_cmd_if tf ();
    ata_host_end ata_host_end_inst (.sys_clk_in(sys_clk), .rst_b_in(rst_b), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .tf(tf.host_end));
    ata_dev_end #(.MIN_LIMIT_US(MIN_US)) ata_dev_end_inst (.sys_clk_in(sys_clk),
        .rst_b_in(rst_b), .tf(tf.dev_end), .epc_enabled_in(epc), .power_cond_in(pc),
        .stream_supported_in(sup), .ident_limit_unit_in(ident), .strm_start_in(s_go),
        .strm_id_in(s_id), .strm_limit_in(s_lim), .strm_done_in(s_end), .lba_mode_out(lba),
        .strm_valid_out(vld), .strm_is_write_out(wrs), .strm_limit_out(lim),
        .strm_overrun_out(ovr));
    ata_link_chk ata_link_chk_inst (.sys_clk_in(sys_clk), .rst_b_in(rst_b),
        .command(tf.command), .cmd_wr(tf.cmd_wr), .status(tf.status), .error(tf.error),
        .count_ret(tf.count_ret), .intrq(tf.intrq));

    // 100 ns clock
    always #50 sys_clk = ~sys_clk;

    // Keep the taskfile of each link write; counting catches refused writes leaking
    always @(posedge sys_clk) begin
        if (tf.cmd_wr) begin
            n_wr <= n_wr + 1;
            snap <= {tf.feat_cur, tf.feat_prev, tf.count_prev, tf.count_cur,
                     tf.dev_head, tf.command};
        end
    end

    // Cycle ceiling so a lost handshake cannot hang the run
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Register port cycles, one-cycle strobes
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // Poll until done; bounded so a dead command shows as a mismatch
    task automatic wait_done(output logic [31:0] v);
        v = 32'h0;
        for (int k = 0; k < 20 && v[RES_DONE_BIT] !== 1'b1; k++)
            bus_rd(HREG_RESULT, v);
        check(v[RES_DONE_BIT], 1'b1);
    endtask

    task automatic run_cmd(input logic [7:0] c, output logic [31:0] v);
        bus_wr(HREG_CMD, {24'h0, c});
        wait_done(v);
    endtask

    task automatic strm_pulse(input logic stop, input logic [39:0] l);
        @(posedge sys_clk);
        s_lim <= l;
        if (stop) s_end <= 1'b1;
        else s_go <= 1'b1;
        @(posedge sys_clk);
        s_go <= 1'b0;
        s_end <= 1'b0;
        #1;
    endtask

    initial begin
        rows = '{'{8'h00, 1'b0, 3'h0, 1'b1, 24'h5000FF}, '{8'h80, 1'b0, 3'h3, 1'b1, 24'h500000},
            '{8'h00, 1'b1, 3'h0, 1'b1, 24'h500081}, '{8'h80, 1'b1, 3'h1, 1'b1, 24'h500082},
            '{8'h40, 1'b1, 3'h2, 1'b1, 24'h500083}, '{8'h00, 1'b1, 3'h3, 1'b1, 24'h500001},
            '{8'h00, 1'b1, 3'h4, 1'b1, 24'h500000}, '{8'h80, 1'b0, 3'h2, 1'b1, 24'h5000FF},
            '{8'h2F, 1'b0, 3'h0, 1'b1, 24'h5000FF}, '{8'h19, 1'b0, 3'h0, 1'b1, 24'h5104FF},
            '{8'h2B, 1'b0, 3'h0, 1'b0, 24'h5104FF}, '{8'h00, 1'b0, 3'h4, 1'b1, 24'h500000}};
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        bus_rd(HREG_RESULT, r);
        check(r[25:0], 26'h0500000);
        bus_rd(8'hF0, r);
        check(r, 32'h0);
        $display("test done: reset");
        foreach (rows[i]) begin
            @(posedge sys_clk);
            epc <= rows[i].epc;
            pc <= rows[i].pc;
            sup <= rows[i].sup;
            run_cmd(rows[i].cmd, r);
            check(r[23:0], rows[i].res);
        end
        check({vld[5], wrs[5]}, 2'b11);
        $display("test done: table");
        bus_wr(HREG_FACTOR, 32'h3);
        bus_wr(HREG_ALLOC, 32'hA55A);
        run_cmd(8'h57, r);
        check({snap[47:46], snap[42:40]}, 5'b11010);
        check({snap[39:16], snap[7:0]}, {24'h03A55A, OP_STREAM_CFG});
        check({snap[15:14], lba}, 3'b011);
        run_cmd(8'h13, r);
        check({vld[2], wrs[2], lba}, 3'b100);
        $display("test done: replace");
        strm_pulse(1'b0, 40'h0);
        check(lim, 40'h6);
        strm_pulse(1'b1, 40'h0);
        strm_pulse(1'b0, 40'h1);
        check(lim, 40'(MIN_US));
        repeat (30) @(posedge sys_clk);
        #1 check(ovr, 1'b0);
        repeat (30) @(posedge sys_clk);
        #1 check(ovr, 1'b1);
        strm_pulse(1'b1, 40'h0);
        $display("test done: limits");
        run_cmd(8'h11, r);
        check({r[23:8], vld[2]}, {16'h5000, 1'b0});
        w0 = n_wr;
        bus_wr(HREG_CMD, 32'h0);
        bus_wr(HREG_CMD, 32'h80);
        wait_done(r);
        check({40'(n_wr - w0), snap[7:0]}, {40'h1, OP_POWER_QUERY});
        $display("test done: busy");
        report_and_stop();
    end
endmodule // ata_power_stream_cmd_handler_tb
